// [vpo_pkg.sv]
package vpo_pkg;

  // widths of the raster counters and the bus
  localparam int CNT_W  = 12;
  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] VPO_CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] VPO_HCROP_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] VPO_VCROP_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] VPO_DECIM_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] VPO_VBI_OFS    = 8'h10;
  localparam logic [ADDR_W-1:0] VPO_STATUS_OFS = 8'h14;

  // control register field positions
  localparam int CTRL_PORT16   = 0;
  localparam int CTRL_EMBED    = 1;
  localparam int CTRL_VIP      = 2;
  localparam int CTRL_VBI_LO   = 3;
  localparam int CTRL_FRAMES   = 5;
  localparam int CTRL_CLK_GATE = 6;
  localparam int CTRL_W        = 7;

  // window fields: start in [11:0], length in [27:16]
  localparam int WIN_START_LO = 0;
  localparam int WIN_LEN_LO   = 16;

  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST      = 7'h00;
  localparam logic [CNT_W-1:0]  HSTART_RST    = 12'h010;
  localparam logic [CNT_W-1:0]  HLEN_RST      = 12'h2C0;
  localparam logic [CNT_W-1:0]  VSTART_RST    = 12'h014;
  localparam logic [CNT_W-1:0]  VLEN_RST      = 12'h1C0;
  localparam logic [7:0]        DECIM_RST     = 8'h00;
  localparam logic [CNT_W-1:0]  VBI_FIRST_RST = 12'h00A;
  localparam logic [CNT_W-1:0]  VBI_COUNT_RST = 12'h00A;

  // blanking levels and timing code bytes
  localparam logic [7:0] BLANK_Y   = 8'h10;
  localparam logic [7:0] BLANK_C   = 8'h80;
  localparam logic [7:0] CODE_ONES = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;

  // blanking-data handling
  typedef enum logic [1:0] {
    VPO_VBI_OFF   = 2'b00,
    VPO_VBI_LINE  = 2'b01,
    VPO_VBI_FRAME = 2'b10
  } vpo_vbi_e;

  // one pixel offered by the decoder core
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [7:0] vbi_a;
    logic [7:0] vbi_b;
  } vpo_pix_s;

  // raster position of the pixel being sent
  typedef struct packed {
    logic [CNT_W-1:0] h;
    logic [CNT_W-1:0] v;
    logic             field;
  } vpo_pos_s;

endpackage

// [vpo_raster.sv]
`timescale 1ns/100ps
`default_nettype none
// free-running line and field counters, advanced once per pixel
module vpo_raster
  import vpo_pkg::*;
#(
  parameter int H_TOTAL = 800,
  parameter int V_TOTAL = 500
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pixel advance
  input  wire logic adv,
  // current position
  output vpo_pos_s  pos
);

  localparam logic [CNT_W-1:0] H_LAST = CNT_W'(H_TOTAL - 1);
  localparam logic [CNT_W-1:0] V_LAST = CNT_W'(V_TOTAL - 1);

  wire logic end_line  = (pos.h == H_LAST);
  wire logic end_field = end_line && (pos.v == V_LAST);

  // counters keep running in every mode so blanking timing never stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= '0;
    end else if (adv) begin
      pos.h <= end_line ? '0 : pos.h + 1'b1;
      if (end_line) begin
        pos.v <= end_field ? '0 : pos.v + 1'b1;
      end
      if (end_field) begin
        pos.field <= ~pos.field;
      end
    end
  end

endmodule
`default_nettype wire

// [vpo_top.sv]
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 4:2:2 stream, port 8 or 16 bits
// - 8-bit: chroma byte then luma byte
// - 8-bit: two sample clocks per pixel
// - blanking pixels sent; clocked per mode
// - out-of-range codes mark active, line, field
// - two code formats selectable
// - crop window drives active flag
// - drop fields or frames at intervals
// - VBI line mode: raw data on chosen lines
// - VBI frame mode: every line raw data
// - VIP: raw samples, task bit on VBI lines
// - VIP: protection bits zero, no ancillary
// - VIP enable picks code behaviour
// - output clock inverted, gated, rate per mode
// - 16-bit luma high, chroma low; else low off
// - valid alone marks captured pixels, VBI lines too
module vpo_top
  import vpo_pkg::*;
#(
  parameter int H_TOTAL = 800,
  parameter int V_TOTAL = 500
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sample clock pin
  input  wire logic              full_rate_sample_clock,
  // pixels from the decoder core
  input  wire vpo_pix_s          pix_in,
  output logic                   pix_take,
  // pixel port pins
  output logic      [7:0]        upper_video_byte,
  output logic      [7:0]        lower_video_byte,
  output logic                   lower_video_byte_oe,
  output logic                   gated_output_clock,
  output logic                   half_rate_pixel_clock,
  output logic                   line_start_strobe_n,
  output logic                   field_start_strobe_n,
  output logic                   active_region,
  output logic                   vertical_active,
  output logic                   valid_pixel,
  output logic                   even_field,
  output logic                   blue_chroma_phase_flag
);

  // true when x lies in [start, start+len)
  // one spare bit keeps columns left of start from wrapping into the window
  function automatic logic in_win(input logic [CNT_W-1:0] x, input logic [CNT_W-1:0] start,
                                  input logic [CNT_W-1:0] len);
    logic [CNT_W:0] rel;
    rel = {1'b0, x} - {1'b0, start};
    in_win = !rel[CNT_W] && (rel < {1'b0, len});
  endfunction

  // software settings and live decimation state
  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  hstart;
  logic [CNT_W-1:0]  hlen;
  logic [CNT_W-1:0]  vstart;
  logic [CNT_W-1:0]  vlen;
  logic [7:0]        decim;
  logic [CNT_W-1:0]  vbi_first;
  logic [CNT_W-1:0]  vbi_count;
  logic              drop_now;
  vpo_pos_s          pos;

  // control register fields
  wire logic     port16   = ctrl[CTRL_PORT16];
  wire logic     embed_en = ctrl[CTRL_EMBED];
  wire logic     vip_mode_enable = ctrl[CTRL_VIP];
  wire vpo_vbi_e vbi_mode = vpo_vbi_e'(ctrl[CTRL_VBI_LO +: 2]);
  wire logic     frames   = ctrl[CTRL_FRAMES];
  wire logic     clk_gate = ctrl[CTRL_CLK_GATE];

  // address decode; zero wait states so pready is tied high
  wire logic acc      = psel && penable;
  wire logic hit_ctrl = (paddr == VPO_CTRL_OFS);
  wire logic hit_h    = (paddr == VPO_HCROP_OFS);
  wire logic hit_v    = (paddr == VPO_VCROP_OFS);
  wire logic hit_dec  = (paddr == VPO_DECIM_OFS);
  wire logic hit_vbi  = (paddr == VPO_VBI_OFS);
  wire logic hit_stat = (paddr == VPO_STATUS_OFS);
  wire logic hit_any  = hit_ctrl | hit_h | hit_v | hit_dec | hit_vbi | hit_stat;
  wire logic wr       = acc && pwrite;

  // every register answers at once, so no transfer is ever stretched
  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any; // unmapped address answers with an error

  // read mux; status shows live raster and decimation state
  wire logic [31:0] rd_status = {17'h0, port16, drop_now, pos.field, pos.v};
  assign prdata = hit_ctrl ? {25'h0, ctrl} :
                  hit_h    ? {4'h0, hlen, 4'h0, hstart} :
                  hit_v    ? {4'h0, vlen, 4'h0, vstart} :
                  hit_dec  ? {24'h0, decim} :
                  hit_vbi  ? {4'h0, vbi_count, 4'h0, vbi_first} :
                  hit_stat ? rd_status : 32'h0;

  // register writes; the status word is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RST;
      hstart    <= HSTART_RST;
      hlen      <= HLEN_RST;
      vstart    <= VSTART_RST;
      vlen      <= VLEN_RST;
      decim     <= DECIM_RST;
      vbi_first <= VBI_FIRST_RST;
      vbi_count <= VBI_COUNT_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl <= pwdata[CTRL_W-1:0];
      if (hit_h) begin
        hstart <= pwdata[WIN_START_LO +: CNT_W];
        hlen   <= pwdata[WIN_LEN_LO +: CNT_W];
      end
      if (hit_v) begin
        vstart <= pwdata[WIN_START_LO +: CNT_W];
        vlen   <= pwdata[WIN_LEN_LO +: CNT_W];
      end
      if (hit_dec) decim <= pwdata[7:0];
      if (hit_vbi) begin
        vbi_first <= pwdata[WIN_START_LO +: CNT_W];
        vbi_count <= pwdata[WIN_LEN_LO +: CNT_W];
      end
    end
  end

  // sample clock pin
  // synchroniser stages, settled level and the divided clock
  logic [2:0] clk_sync;
  logic       clk_lvl;
  logic       half_clk;

  // three flops; a level counts only once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync <= 3'h0;
      clk_lvl  <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], full_rate_sample_clock};
      if (clk_sync[1] == clk_sync[2]) clk_lvl <= clk_sync[2];
    end
  end

  wire logic fr_tick  = !clk_lvl && clk_sync[1] && clk_sync[2];
  wire logic pix_tick = fr_tick && !half_clk; // one pixel per two sample clock rises
  wire logic byte2    = fr_tick && half_clk;  // second byte slot of the pixel

  // half-rate clock divided from the sampled full-rate clock
  // its phase is fixed by the first rise detected after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_clk <= 1'b0;
    end else if (fr_tick) begin
      half_clk <= !half_clk;
    end
  end

  // raster position advances once per pixel tick
  vpo_raster #(
    .H_TOTAL (H_TOTAL),
    .V_TOTAL (V_TOTAL)
  ) u_raster (
    .pclk    (pclk),
    .presetn (presetn),
    .adv     (pix_tick),
    .pos     (pos)
  );

  // the core must offer the next pixel in the tick cycle
  assign pix_take = pix_tick;

  // region decode
  // windows are assumed not to run past the counter's end
  wire logic [CNT_W-1:0] hend = hstart + hlen;
  wire logic h_act   = in_win(pos.h, hstart, hlen);
  wire logic v_act   = in_win(pos.v, vstart, vlen);
  wire logic vbi_sel = in_win(pos.v, vbi_first, vbi_count);
  wire logic vbi_line = (vbi_mode == VPO_VBI_FRAME) ||
                        ((vbi_mode == VPO_VBI_LINE) && vbi_sel);
  wire logic img_line = v_act && !vbi_line; // frame mode leaves no image line

  // code slots sit just before and just after the active window
  wire logic sav0  = (pos.h == hstart - 12'h002);
  wire logic sav1  = (pos.h == hstart - 12'h001);
  wire logic eav0  = (pos.h == hend);
  wire logic eav1  = (pos.h == hend + 12'h001);
  wire logic code0 = embed_en && (sav0 || eav0);
  wire logic code1 = embed_en && (sav1 || eav1);

  // status byte: VIP keeps task bit and zero protection, other format hamming
  wire logic cf = pos.field;
  wire logic cv = !v_act;
  wire logic ch = eav1;
  wire logic [7:0] xy_vip = {vbi_line, cf, cv, ch, 4'h0};
  wire logic [7:0] xy_std = {1'b1, cf, cv, ch, cv ^ ch, cf ^ ch, cf ^ cv, cf ^ cv ^ ch};
  wire logic [7:0] xy     = vip_mode_enable ? xy_vip : xy_std;

  // Cb on even pixel numbers so every line starts with Cb
  wire logic cb_phase = !pos.h[0];
  wire logic [7:0] chroma = cb_phase ? pix_in.cb : pix_in.cr;

  // byte selection; codes win over data, raw VBI over image
  wire logic [7:0] next_c = code0 ? CODE_ONES :
                            code1 ? CODE_ZERO :
                            (h_act && vbi_line) ? pix_in.vbi_a :
                            (h_act && img_line) ? chroma : BLANK_C;
  wire logic [7:0] next_y = code0 ? CODE_ZERO :
                            code1 ? xy :
                            (h_act && vbi_line) ? pix_in.vbi_b :
                            (h_act && img_line) ? pix_in.y : BLANK_Y;

  // dropped units raise no valid; blanking and codes carry on
  wire logic next_valid = h_act && (img_line || vbi_line) && !drop_now && !code0 && !code1;
  wire logic next_line_n  = !(pos.h == '0);
  wire logic next_field_n = !((pos.h == '0) && (pos.v == '0));

  // temporal decimation
  // lowering decim mid-count can delay the next drop by up to 256 units
  logic [7:0] dec_cnt;
  wire logic unit_start = pix_tick && !next_field_n && (!frames || !pos.field);
  wire logic dec_last   = (dec_cnt == decim - 8'h01);
  wire logic [7:0] next_dec_cnt = (decim == 8'h00 || dec_last) ? 8'h00 : dec_cnt + 8'h01;

  // one unit out of every decim is dropped; zero disables it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt  <= 8'h00;
      drop_now <= 1'b0;
    end else if (unit_start) begin
      dec_cnt  <= next_dec_cnt;
      drop_now <= (decim != 8'h00) && dec_last;
    end
  end

  // output port
  // luma kept for the second byte slot of 8-bit mode
  logic [7:0] held_y;

  // 16-bit: luma high, chroma low; 8-bit: chroma then luma on the high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_video_byte <= 8'h00;
      lower_video_byte <= 8'h00;
      held_y           <= 8'h00;
    end else if (pix_tick) begin
      upper_video_byte <= port16 ? next_y : next_c;
      lower_video_byte <= port16 ? next_c : 8'h00;
      held_y           <= next_y;
    end else if (byte2 && !port16) begin
      upper_video_byte <= held_y;
    end
  end

  // flags change only at pixel boundaries so they align with both bytes
  // a crop change mid-line applies from the next pixel and may cut that line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_region          <= 1'b0;
      vertical_active        <= 1'b0;
      valid_pixel            <= 1'b0;
      even_field             <= 1'b0;
      blue_chroma_phase_flag <= 1'b0;
      line_start_strobe_n    <= 1'b1;
      field_start_strobe_n   <= 1'b1;
    end else if (pix_tick) begin
      active_region          <= h_act && v_act;
      vertical_active        <= v_act;
      valid_pixel            <= next_valid;
      even_field             <= pos.field;
      blue_chroma_phase_flag <= cb_phase;
      line_start_strobe_n    <= next_line_n;
      field_start_strobe_n   <= next_field_n;
    end
  end

  // low byte is released in 8-bit mode
  assign lower_video_byte_oe = port16;

  // clock out is inverted so data changes on its falling edge; gating optional
  // gating saves edges, but then no blanking or strobes reach the receiver
  wire logic gate = !clk_gate || valid_pixel;
  assign gated_output_clock    = gate && (port16 ? !half_clk : !clk_lvl);
  assign half_rate_pixel_clock = half_clk;

endmodule
`default_nettype wire

// [vpo_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// pin-level checker of the pixel output port
module vpo_top_asserts
  import vpo_pkg::*;
(
  // clock, reset and apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // pixel port
  input wire logic              pix_take,
  input wire logic [7:0]        lower_video_byte,
  input wire logic              lower_video_byte_oe,
  input wire logic              half_rate_pixel_clock,
  input wire logic              line_start_strobe_n,
  input wire logic              field_start_strobe_n,
  input wire logic              active_region,
  input wire logic              vertical_active,
  input wire logic              even_field,
  input wire logic              blue_chroma_phase_flag
);
  default clocking dclk @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] off_cnt;
  // time since release; the byte only empties at the next pixel, so wait 40 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_cnt <= 6'h00;
    else if (lower_video_byte_oe) off_cnt <= 6'h00;
    else if (off_cnt != 6'h3F) off_cnt <= off_cnt + 6'h01;
  end
  // line start, then one pixel low and back high
  sequence s_line_go;
    $fell(line_start_strobe_n);
  endsequence
  sequence s_one_pixel;
    (!line_start_strobe_n)[*8] ##[1:16] line_start_strobe_n;
  endsequence
  a_unmapped_err: assert property (psel && penable && paddr > 8'h14
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_lower_off: assert property (off_cnt > 6'h28 |-> lower_video_byte == 8'h00)
    else $error("released lower byte not empty");
  a_take_space: assert property (pix_take |=> (!pix_take)[*8])
    else $error("pixel ticks too close");
  a_half_tick: assert property ($rose(half_rate_pixel_clock) |-> $past(pix_take))
    else $error("half clock rise without pixel tick");
  a_line_pulse: assert property (s_line_go |-> s_one_pixel)
    else $error("line strobe not one pixel long");
  a_field_on_line: assert property ($fell(field_start_strobe_n) |-> s_line_go)
    else $error("field strobe away from line start");
  a_cb_first: assert property (s_line_go |-> blue_chroma_phase_flag)
    else $error("line does not start with blue chroma");
  a_cb_alternate: assert property (pix_take |=>
    blue_chroma_phase_flag != $past(blue_chroma_phase_flag))
    else $error("chroma phase did not alternate");
  a_parity_field: assert property ($changed(even_field) |-> !field_start_strobe_n)
    else $error("field parity moved outside field start");
  a_active_vert: assert property (active_region |-> vertical_active)
    else $error("active outside vertical window");
endmodule
bind vpo_top vpo_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pslverr, .pix_take, .lower_video_byte, .lower_video_byte_oe, .half_rate_pixel_clock,
  .line_start_strobe_n, .field_start_strobe_n, .active_region, .vertical_active,
  .even_field, .blue_chroma_phase_flag);
`default_nettype wire

// [vpo_capture.sv]
`timescale 1ns/100ps
`default_nettype none
// far-side capture logic; samples mid-unit on the gated clock's rising edge
module vpo_capture
  import vpo_pkg::*;
(
  // port pins
  input wire logic       gated_output_clock,
  input wire logic       presetn,
  input wire logic [7:0] upper_video_byte,
  input wire logic [7:0] lower_video_byte,
  input wire logic       valid_pixel,
  input wire logic       blue_chroma_phase_flag,
  input wire logic       line_start_strobe_n,
  input wire logic       field_start_strobe_n,
  // expected stream
  input wire logic       port16,
  input wire logic       vip,
  input wire logic [7:0] exp_y,
  input wire logic [7:0] exp_cb,
  input wire logic [7:0] exp_cr
);
  int          cnt, lines, ffs, last_valid, last_lines, last_ff, bad, fields;
  logic        ph, ls_d, fs_d;
  logic [23:0] hist;
  wire  [7:0]  c_exp = blue_chroma_phase_flag ? exp_cb : exp_cr;
  // per-field tallies, handed over at each field start strobe
  always @(posedge gated_output_clock or negedge presetn) begin
    if (!presetn) begin
      {cnt, lines, ffs, bad, fields} = '0;
      {ph, hist} = '0;
      {ls_d, fs_d} = 2'b11;
    end else begin
      if (!field_start_strobe_n && fs_d) begin
        {last_valid, last_lines, last_ff} = {cnt, lines, ffs};
        {cnt, lines, ffs, ph} = '0;
        fields++;
      end
      if (!line_start_strobe_n && ls_d) lines++;
      if (upper_video_byte == 8'hFF) ffs++;
      if (vip && hist == 24'hFF0000 && upper_video_byte[3:0] != 4'h0) bad++;
      // only flagged pixels are taken; both bytes of a pixel in byte mode
      if (valid_pixel) begin
        cnt++;
        if (port16 && (upper_video_byte !== exp_y || lower_video_byte !== c_exp)) bad++;
        if (!port16 && upper_video_byte !== (ph ? exp_y : c_exp)) bad++;
        ph = ~ph;
      end
      hist = {hist[15:0], upper_video_byte};
      {ls_d, fs_d} = {line_start_strobe_n, field_start_strobe_n};
    end
  end
endmodule
`default_nettype wire

// [vpo_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// bench: apb set-up, free-running sample clock, capture model on the far side
module vpo_top_tb
  import vpo_pkg::*;
();
  localparam int VT = 10;
  logic        pclk = 1'b0, presetn = 1'b0, full_rate_sample_clock = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, port16 = 1'b0, vip = 1'b0;
  logic [7:0]  paddr = 8'h00, ey = 8'h00, ecb = 8'h00, ecr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [7:0]  upper_video_byte, lower_video_byte;
  logic        pready, pslverr, pix_take, lower_video_byte_oe, gated_output_clock;
  logic        half_rate_pixel_clock, line_start_strobe_n, field_start_strobe_n;
  logic        active_region, vertical_active, valid_pixel, even_field, blue_chroma_phase_flag;
  vpo_pix_s    pix_in = 40'h5566773344;
  int          bad_count = 0, samples_checked = 0, n;
  // the sample clock runs at one eighth of pclk and toggles on pclk falling edges
  always #12.5 pclk = ~pclk;
  always #100 full_rate_sample_clock = ~full_rate_sample_clock;
  vpo_top #(.H_TOTAL(40), .V_TOTAL(VT)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .full_rate_sample_clock, .pix_in, .pix_take, .upper_video_byte, .lower_video_byte,
    .lower_video_byte_oe, .gated_output_clock, .half_rate_pixel_clock, .line_start_strobe_n,
    .field_start_strobe_n, .active_region, .vertical_active, .valid_pixel, .even_field,
    .blue_chroma_phase_flag);
  vpo_capture p (
    .gated_output_clock, .presetn, .upper_video_byte, .lower_video_byte, .valid_pixel,
    .blue_chroma_phase_flag, .line_start_strobe_n, .field_start_strobe_n, .port16, .vip,
    .exp_y(ey), .exp_cb(ecb), .exp_cr(ecr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; starts off an edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     output logic [31:0] r, output logic x);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    x = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, d, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0, d, e);
    check(d, x);
    check(e, xe);
  endtask
  task automatic wait_fields(input int k);
    int t;
    t = p.fields + k;
    for (int i = 0; i < 40000 && p.fields < t; i++) @(posedge pclk);
    check(p.fields >= t, 1'b1);
  endtask
  // set the mode, skip the partial field, then judge one whole field
  task automatic run(input logic [31:0] c, input logic [7:0] y, cb, cr);
    int b;
    wr(VPO_CTRL_OFS, c);
    {port16, vip, ey, ecb, ecr} <= {c[0], c[2], y, cb, cr};
    wait_fields(1);
    b = p.bad;
    wait_fields(1);
    check(p.bad - b, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(VPO_CTRL_OFS, 32'h0, 1'b0);
    rd(VPO_HCROP_OFS, 32'h02C00010, 1'b0);
    rd(VPO_VCROP_OFS, 32'h01C00014, 1'b0);
    rd(VPO_DECIM_OFS, 32'h0, 1'b0);
    rd(VPO_VBI_OFS, 32'h000A000A, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    wr(VPO_STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, VPO_STATUS_OFS, 32'h0, d, e);
    check(d[14], 1'b0);
    $display("test registers done");
    wr(VPO_HCROP_OFS, 32'h00080004);
    wr(VPO_VCROP_OFS, 32'h00060002);
    run(32'h01, 8'h55, 8'h66, 8'h77);
    check(lower_video_byte_oe, 1'b1);
    check(p.last_valid, 32'h30);
    check(p.last_lines, VT);
    $display("test wide port done");
    run(32'h11, 8'h44, 8'h33, 8'h33);
    check(p.last_valid, 32'h50);
    $display("test blanking frame done");
    // blanking data on lines 8 and 9 only, image lines stay as cropped
    wr(VPO_VBI_OFS, 32'h00020008);
    wr(VPO_CTRL_OFS, 32'h09);
    wait_fields(2);
    check(p.last_valid, 32'h40);
    $display("test blanking lines done");
    wr(VPO_DECIM_OFS, 32'h2);
    run(32'h01, 8'h55, 8'h66, 8'h77);
    n = p.last_valid;
    wait_fields(1);
    check(n + p.last_valid, 32'h30);
    check(p.last_lines, VT);
    wr(VPO_DECIM_OFS, 32'h0);
    $display("test decimation done");
    // byte-wide port in both code formats
    for (int k = 0; k < 2; k++) begin
      run(k ? 32'h06 : 32'h02, 8'h55, 8'h66, 8'h77);
      check(lower_video_byte_oe, 1'b0);
      check(p.last_valid, 32'h60);
      check(p.last_ff, 2 * VT);
    end
    $display("test byte port done");
    wrap_up;
  end
  // watchdog
  initial begin
    #(25 * 100000);
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
